/* hdl/ptt_pkg.sv */
/*
  Shared definitions for the power transfer termination logic: register map,
  field positions, reset values, termination codes, states and carrier structs.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package ptt_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_CEP_COUNT = 5'h10;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  localparam int STATUS_OUTPUT_BIT = 0;
  localparam int STATUS_PMA_BIT = 1;
  localparam int STATUS_TAKEOVER_BIT = 2;
  localparam int STATUS_NOCONV_BIT = 3;
  localparam int STATUS_STATE_LSB = 4;
  localparam int STATUS_CODE_LSB = 8;

  localparam int IRQ_WIDTH = 5;
  localparam int IRQ_SENT_BIT = 0;
  localparam int IRQ_ADAPTER_BIT = 1;
  localparam int IRQ_HOT_BIT = 2;
  localparam int IRQ_NOCONV_BIT = 3;
  localparam int IRQ_FAULT_BIT = 4;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 5'h00;

  // ---------------------------------------------------------------------------
  // Termination codes and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CODE_UNKNOWN = 8'h00;
  localparam logic [7:0] CODE_CHARGE_COMPLETE = 8'h01;
  localparam logic [7:0] CODE_INTERNAL_FAULT = 8'h02;
  localparam logic [7:0] CODE_OVER_TEMPERATURE = 8'h03;
  localparam logic [7:0] CODE_OVER_VOLTAGE = 8'h04;

  localparam int CEP_COUNT_WIDTH = 7;
  localparam logic [6:0] CEP_LIMIT = 7'h40;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_OUTPUT_OFF, ST_SEND, ST_DONE} ptt_state_t;

  typedef struct packed {
    logic adapter_present;
    logic adapter_enable;
    logic thermal_control_high;
    logic thermal_control_low;
    logic temp_hot;
    logic junction_hot;
    logic current_limit_pin_too_small;
    logic term_above_limit;
    logic rectifier_node_converged;
    logic tmem_high;
    logic term_resistor_fitted;
    logic load_above_100ma;
    logic load_above_350ma;
  } ptt_flags_t;

  localparam int FLAGS_WIDTH = $bits(ptt_flags_t);

  typedef struct packed {
    logic pma_eoc;
    logic [7:0] code;
  } ptt_msg_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ptt_avs_req_t;

endpackage

/* hdl/ptt_sync.sv */
/*
  Two-flip-flop synchroniser for a vector of independent level flags.
  Assumes each bit is a slow level; no multi-bit coherence is given.
*/
`timescale 1ns/100ps
module ptt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import ptt_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ptt_sync_state_t;

  ptt_sync_state_t state;
  ptt_sync_state_t next_state;

  // The first stage feeds only the second stage, so metastability stays contained.
  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;
endmodule

/* hdl/ptt_pin_select.sv */
/*
  Drives the two shared open-drain pins either as rectifier boost outputs or as
  power-good and pad-detect outputs. Assumes synchronised flags on clock_in.
*/
`timescale 1ns/100ps
module ptt_pin_select (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire ptt_pkg::ptt_flags_t flags_in,
  input wire logic pma_mode_in,
  input wire logic power_good_in,
  output logic boost_low_pin_oe_out,
  output logic boost_mid_pin_oe_out
);
  import ptt_pkg::*;

  typedef struct packed {
    logic low_oe;
    logic mid_oe;
  } ptt_pin_state_t;

  ptt_pin_state_t state;
  ptt_pin_state_t next_state;

  // Both pins are active low, so asserting one means enabling its pull-down.
  always_comb begin
    if (flags_in.term_resistor_fitted) begin
      next_state.low_oe = !flags_in.load_above_100ma && !flags_in.load_above_350ma;
      next_state.mid_oe = !flags_in.load_above_350ma;
    end else begin
      next_state.low_oe = power_good_in;
      next_state.mid_oe = !pma_mode_in && flags_in.tmem_high;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign boost_low_pin_oe_out = state.low_oe;
  assign boost_mid_pin_oe_out = state.mid_oe;
endmodule

/* hdl/ptt_termination.sv */
/*
  Termination decision logic of a dual-protocol wireless power receiver, with an
  Avalon-MM register slave and a level interrupt. Assumes the analog comparators
  arrive as asynchronous flags, and that the message modulator, session control
  and protocol detection run on clock_in.
*/
`timescale 1ns/100ps
// Overview of operation
// - Termination codes: 0x00 unknown to 0x04 over voltage; 0x05-0x08 never sent.
// - Send only on a listed trigger (code adds internal fault on junction hot or current-limit pin too small); unknown code when adapter exceeds detect level.
// - Thermal/control input high sends charge complete, packet or end-of-charge symbol.
// - Thermal/control input low or thermistor hot sends over temperature.
// - WPC startup: 64 control error packets without convergence sends over voltage.
// - Adapter above enable level: output off first, then end message sent.
// - After adapter takeover, drive adapter switch control on.
// - PMA: termination pin above limit pin disables output, sends end-of-charge.
// - Termination-current end-of-charge only with PMA transmitter, never WPC.
// - Shared pins boost rectifier only with termination resistor; else power-good, pad detect.
// - Boost: both below 100 mA, mid only to 350 mA, none above.
module ptt_termination (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire ptt_pkg::ptt_avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire ptt_pkg::ptt_flags_t analog_flags_in,
  input wire logic pma_mode_in,
  input wire logic session_start_in,
  input wire logic cep_sent_in,
  input wire logic msg_ready_in,
  output logic msg_valid_out,
  output ptt_pkg::ptt_msg_t msg_out,
  output logic output_enable_out,
  output logic adapter_switch_out,
  output logic boost_low_pin_out,
  output logic boost_low_pin_oe_out,
  output logic boost_mid_pin_out,
  output logic boost_mid_pin_oe_out,
  output logic irq_out
);
  import ptt_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ptt_state_t fsm;
    ptt_msg_t msg;
    logic takeover;
    logic converged;
    logic noconv;
    logic [CEP_COUNT_WIDTH-1:0] cep_count;
    logic [1:0] ctrl;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic ack;
    logic [31:0] readdata;
  } ptt_core_state_t;

  ptt_core_state_t state;
  ptt_core_state_t next_state;
  ptt_flags_t flags;
  logic power_good;

  // ---------------------------------------------------------------------------
  // Input synchronisation and pin sharing
  // ---------------------------------------------------------------------------
  ptt_sync #(
    .WIDTH(FLAGS_WIDTH)
  ) u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(analog_flags_in),
    .sync_out(flags)
  );

  // Power good drops as soon as a termination starts.
  assign power_good = (state.fsm == ST_RUN) && state.ctrl[CTRL_ENABLE_BIT] && state.converged;

  ptt_pin_select u_pins (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .flags_in(flags),
    .pma_mode_in(pma_mode_in),
    .power_good_in(power_good),
    .boost_low_pin_oe_out(boost_low_pin_oe_out),
    .boost_mid_pin_oe_out(boost_mid_pin_oe_out)
  );

  assign boost_low_pin_out = 1'b0;
  assign boost_mid_pin_out = 1'b0;

  // ---------------------------------------------------------------------------
  // Termination choice
  // ---------------------------------------------------------------------------
  // Returns {trigger, code}. Faults outrank heat, heat outranks convergence,
  // then adapter, then charge complete, so the most serious reason reaches the
  // transmitter when several conditions rise together.
  function automatic logic [8:0] choose_code(input ptt_flags_t f, input logic pma,
                                             input logic noconv, input logic force_cc);
    logic [8:0] pick;
    pick = {1'b0, CODE_UNKNOWN};
    if (f.junction_hot || f.current_limit_pin_too_small) begin
      pick = {1'b1, CODE_INTERNAL_FAULT};
    end else if (f.thermal_control_low || f.temp_hot) begin
      pick = {1'b1, CODE_OVER_TEMPERATURE};
    end else if (noconv && !pma) begin
      pick = {1'b1, CODE_OVER_VOLTAGE};
    end else if (f.adapter_present || f.adapter_enable) begin
      pick = {1'b1, CODE_UNKNOWN};
    end else if (f.thermal_control_high || force_cc) begin
      pick = {1'b1, CODE_CHARGE_COMPLETE};
    end else if (pma && f.term_above_limit) begin
      pick = {1'b1, CODE_CHARGE_COMPLETE};
    end
    return pick;
  endfunction

  logic [8:0] pick;
  // The choice is made every cycle; only the run state acts on it.
  assign pick = choose_code(flags, pma_mode_in, state.noconv, state.ctrl[CTRL_FORCE_BIT]);

  // ---------------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] read_reg(input ptt_core_state_t s, input logic [4:0] addr,
                                           input logic pma);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (addr == REG_CTRL) begin
      d[1:0] = s.ctrl;
    end else if (addr == REG_STATUS) begin
      d[STATUS_OUTPUT_BIT] = (s.fsm == ST_RUN) && s.ctrl[CTRL_ENABLE_BIT];
      d[STATUS_PMA_BIT] = pma;
      d[STATUS_TAKEOVER_BIT] = s.takeover;
      d[STATUS_NOCONV_BIT] = s.noconv;
      d[STATUS_STATE_LSB +: 2] = s.fsm;
      d[STATUS_CODE_LSB +: 8] = s.msg.code;
    end else if (addr == REG_IRQ_STATUS) begin
      d[IRQ_WIDTH-1:0] = s.irq_status;
    end else if (addr == REG_IRQ_MASK) begin
      d[IRQ_WIDTH-1:0] = s.irq_mask;
    end else if (addr == REG_CEP_COUNT) begin
      d[CEP_COUNT_WIDTH-1:0] = s.cep_count;
    end
    return d;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic req;
  logic wr_commit;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [IRQ_WIDTH-1:0] irq_clr;

  assign req = avs_req_in.read || avs_req_in.write;
  assign wr_commit = avs_req_in.write && state.ack && avs_req_in.byteenable[0];

  always_comb begin
    next_state = state;
    irq_set = '0;
    irq_clr = '0;

    // ------------------------------
    // Bus answer
    // ------------------------------
    // One wait cycle per access; the answer stands in the second cycle.
    // Read data come from a register, so the address decode never
    // reaches the bus output combinationally.
    next_state.ack = req && !state.ack;
    if (avs_req_in.read && !state.ack) begin
      next_state.readdata = read_reg(state, avs_req_in.address, pma_mode_in);
    end

    // ------------------------------
    // Convergence
    // ------------------------------
    // Convergence is latched for the session, so a later dip of the
    // rectifier does not restart the count.
    if (flags.rectifier_node_converged) begin
      next_state.converged = 1'b1;
    end

    // Convergence counting only matters while a WPC session is starting up.
    // The count stops at its limit, so a late read still shows why it ended.
    if (state.fsm == ST_RUN && !pma_mode_in && !state.converged && cep_sent_in
        && state.cep_count != CEP_LIMIT) begin
      next_state.cep_count = state.cep_count + 7'h01;
      if (state.cep_count + 7'h01 == CEP_LIMIT) begin
        next_state.noconv = 1'b1;
        irq_set[IRQ_NOCONV_BIT] = 1'b1;
      end
    end

    // ------------------------------
    // Termination sequence
    // ------------------------------
    // The force bit is a level: while set, every new session ends at once
    // with charge complete, so software clears it before a restart.
    case (state.fsm)
      ST_RUN: begin
        if (state.ctrl[CTRL_ENABLE_BIT] && pick[8]) begin
          next_state.msg.code = pick[7:0];
          next_state.msg.pma_eoc = pma_mode_in;
          next_state.takeover = flags.adapter_enable;
          next_state.fsm = ST_OUTPUT_OFF;
          irq_set[IRQ_ADAPTER_BIT] = flags.adapter_enable;
          irq_set[IRQ_HOT_BIT] = (pick[7:0] == CODE_OVER_TEMPERATURE);
          irq_set[IRQ_FAULT_BIT] = (pick[7:0] == CODE_INTERNAL_FAULT);
        end
      end
      // One cycle with the output off before the message is offered.
      ST_OUTPUT_OFF: begin
        next_state.fsm = ST_SEND;
      end
      // A transmitter that never answers keeps the block here; the output
      // is already off, so only time is lost.
      ST_SEND: begin
        if (msg_ready_in) begin
          next_state.fsm = ST_DONE;
          irq_set[IRQ_SENT_BIT] = 1'b1;
        end
      end
      // Only a new session leaves this state: one message per session.
      ST_DONE: begin
        if (session_start_in) begin
          next_state.fsm = ST_RUN;
          next_state.takeover = 1'b0;
          next_state.converged = 1'b0;
          next_state.noconv = 1'b0;
          next_state.cep_count = '0;
        end
      end
      default: begin
        next_state.fsm = ST_RUN;
      end
    endcase

    // A new session also restarts convergence counting while still running.
    if (state.fsm == ST_RUN && session_start_in) begin
      next_state.converged = 1'b0;
      next_state.noconv = 1'b0;
      next_state.cep_count = '0;
    end

    // ------------------------------
    // Register writes
    // ------------------------------
    // A write lands at the edge that ends the wait, the same edge at which
    // the master sees the answer.
    if (wr_commit) begin
      if (avs_req_in.address == REG_CTRL) begin
        next_state.ctrl = avs_req_in.writedata[1:0];
      end else if (avs_req_in.address == REG_IRQ_STATUS) begin
        irq_clr = avs_req_in.writedata[IRQ_WIDTH-1:0];
      end else if (avs_req_in.address == REG_IRQ_MASK) begin
        next_state.irq_mask = avs_req_in.writedata[IRQ_WIDTH-1:0];
      end
    end

    // ------------------------------
    // Interrupt status
    // ------------------------------
    // A set in the same cycle as its clear wins, so no event is lost.
    next_state.irq_status = (state.irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state.fsm <= ST_RUN;
      state.msg <= '0;
      state.takeover <= 1'b0;
      state.converged <= 1'b0;
      state.noconv <= 1'b0;
      state.cep_count <= '0;
      state.ctrl <= CTRL_RESET;
      state.irq_status <= '0;
      state.irq_mask <= IRQ_MASK_RESET;
      state.ack <= 1'b0;
      state.readdata <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign avs_waitrequest_out = req && !state.ack;
  assign avs_readdata_out = state.readdata;
  assign msg_valid_out = (state.fsm == ST_SEND);
  assign msg_out = state.msg;
  // The output stays off from the trigger onward, before any message leaves.
  assign output_enable_out = (state.fsm == ST_RUN) && state.ctrl[CTRL_ENABLE_BIT];
  // Switching to the adapter only after the transmitter was told to stop
  // avoids feeding the output from two sources at once.
  assign adapter_switch_out = (state.fsm == ST_DONE) && state.takeover
                              && flags.adapter_enable;
  // The interrupt is a plain level; it drops in the cycle after software
  // clears its last unmasked bit.
  assign irq_out = |(state.irq_status & state.irq_mask);
endmodule

/* bench/ptt_termination_checker.sv */
/* Port checker for ptt_termination, bound to every instance of it.
   Assumes comparator flags are held long enough to cross the synchroniser. */
`timescale 1ns/100ps
module ptt_termination_checker (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire ptt_pkg::ptt_avs_req_t avs_req_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire ptt_pkg::ptt_flags_t analog_flags_in,
  input wire logic pma_mode_in,
  input wire logic session_start_in,
  input wire logic cep_sent_in,
  input wire logic msg_ready_in,
  input wire logic msg_valid_out,
  input wire ptt_pkg::ptt_msg_t msg_out,
  input wire logic output_enable_out,
  input wire logic adapter_switch_out,
  input wire logic boost_low_pin_out,
  input wire logic boost_low_pin_oe_out,
  input wire logic boost_mid_pin_out,
  input wire logic boost_mid_pin_oe_out,
  input wire logic irq_out
);
  import ptt_pkg::*;
  ptt_flags_t f;
  assign f = analog_flags_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // ----------
  // Assertions
  // ----------
  // Pins lag the flags by three edges, so five steady samples leave a margin.
  sequence s_pending;
    msg_valid_out && !msg_ready_in;
  endsequence
  sequence s_taken;
    msg_valid_out && msg_ready_in;
  endsequence
  property p_off_first;
    $rose(msg_valid_out) |-> !output_enable_out && !$past(output_enable_out);
  endproperty
  a_code_range: assert property (msg_valid_out |-> msg_out.code <= CODE_OVER_VOLTAGE)
    else $error("termination code out of range");
  a_valid_hold: assert property (s_pending |=> msg_valid_out && $stable(msg_out))
    else $error("message changed before ready");
  a_valid_once: assert property (s_taken |=> !msg_valid_out [*3])
    else $error("second message in one session");
  a_off_first: assert property (p_off_first)
    else $error("message sent before output off");
  a_eoc_mode: assert property (msg_valid_out |-> msg_out.pma_eoc == pma_mode_in)
    else $error("message kind does not match mode");
  a_switch_off: assert property (adapter_switch_out |-> !output_enable_out && !msg_valid_out)
    else $error("adapter switch on too early");
  a_boost_both: assert property ((f.term_resistor_fitted && !f.load_above_100ma) [*5]
    |-> boost_low_pin_oe_out && boost_mid_pin_oe_out)
    else $error("light load boost wrong");
  a_boost_mid: assert property ((f.term_resistor_fitted && f.load_above_100ma
    && !f.load_above_350ma) [*5] |-> !boost_low_pin_oe_out && boost_mid_pin_oe_out)
    else $error("mid load boost wrong");
  a_boost_none: assert property ((f.term_resistor_fitted && f.load_above_350ma) [*5]
    |-> !boost_low_pin_oe_out && !boost_mid_pin_oe_out)
    else $error("heavy load boost wrong");
  a_pad_detect: assert property ((!f.term_resistor_fitted && f.tmem_high && !pma_mode_in) [*5]
    |-> boost_mid_pin_oe_out)
    else $error("pad detect not shown");
endmodule
bind ptt_termination ptt_termination_checker u_ptt_termination_checker (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .avs_req_in(avs_req_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .analog_flags_in(analog_flags_in), .pma_mode_in(pma_mode_in),
  .session_start_in(session_start_in), .cep_sent_in(cep_sent_in),
  .msg_ready_in(msg_ready_in), .msg_valid_out(msg_valid_out), .msg_out(msg_out),
  .output_enable_out(output_enable_out), .adapter_switch_out(adapter_switch_out),
  .boost_low_pin_out(boost_low_pin_out), .boost_low_pin_oe_out(boost_low_pin_oe_out),
  .boost_mid_pin_out(boost_mid_pin_out), .boost_mid_pin_oe_out(boost_mid_pin_oe_out),
  .irq_out(irq_out));

/* bench/ptt_tx_model.sv */
/* Transmitter controller model that takes one termination message per session.
   Assumes the receiver holds valid and message until ready is seen. */
`timescale 1ns/100ps
module ptt_tx_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic msg_valid_in,
  input wire ptt_pkg::ptt_msg_t msg_in,
  input wire logic [3:0] delay_in,
  output logic msg_ready_out,
  output ptt_pkg::ptt_msg_t last_msg_out
);
  import ptt_pkg::*;
  // ----------
  // Acceptance
  // ----------
  // A slow controller waits before ready; ready is one pulse, never a level.
  logic [3:0] waited;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      msg_ready_out <= 1'b0;
      last_msg_out <= '0;
      waited <= 4'h0;
    end else begin
      msg_ready_out <= 1'b0;
      if (msg_valid_in && !msg_ready_out) begin
        waited <= waited + 4'h1;
        if (waited >= delay_in) begin
          msg_ready_out <= 1'b1;
          last_msg_out <= msg_in;
          waited <= 4'h0;
        end
      end
    end
  end
endmodule

/* bench/ptt_termination_test.sv */
/* Self-checking bench for ptt_termination.
   Assumes the bound checker and the transmitter model ptt_tx_model. */
`timescale 1ns/100ps
module ptt_termination_test;
  import ptt_pkg::*;
  logic clock_in, reset_n_in, pma, start, cep, ready, valid, oe, sw, irq;
  logic bl, blo, bm, bmo, wt;
  logic [31:0] rd, q;
  logic [3:0] delay;
  ptt_avs_req_t req;
  ptt_flags_t flags;
  ptt_msg_t msg, rx;
  int fails, check_count;
  ptt_termination u_ptt_termination (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .avs_req_in(req), .avs_readdata_out(rd), .avs_waitrequest_out(wt),
    .analog_flags_in(flags), .pma_mode_in(pma), .session_start_in(start),
    .cep_sent_in(cep), .msg_ready_in(ready), .msg_valid_out(valid), .msg_out(msg),
    .output_enable_out(oe), .adapter_switch_out(sw), .boost_low_pin_out(bl),
    .boost_low_pin_oe_out(blo), .boost_mid_pin_out(bm), .boost_mid_pin_oe_out(bmo),
    .irq_out(irq));
  ptt_tx_model u_ptt_tx_model (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .msg_valid_in(valid), .msg_in(msg), .delay_in(delay), .msg_ready_out(ready),
    .last_msg_out(rx));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clock_in);
    end while (wt !== 1'b0);
    q = rd;
    req <= '0;
    @(posedge clock_in);
  endtask
  task automatic new_session();
    flags <= '0;
    pma <= 1'b0;
    repeat (4) @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic expect_msg(input logic [7:0] code, input logic eoc);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    chk(32'(oe), 32'h0);
    chk(32'(msg), 32'({eoc, code}));
    while (valid === 1'b1 && n < 60) begin
      @(posedge clock_in);
      n++;
    end
    @(posedge clock_in);
    chk(32'(rx), 32'({eoc, code}));
  endtask
  task automatic fire(input ptt_flags_t f, input logic p, input logic [7:0] code);
    pma <= p;
    flags <= f;
    expect_msg(code, p);
    new_session();
  endtask
  task automatic cep_pulses(input int n);
    repeat (n) begin
      cep <= 1'b1;
      @(posedge clock_in);
      cep <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, REG_IRQ_MASK, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    chk(32'({bl, bm}), 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    chk(32'(oe), 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    chk(32'(oe), 32'h1);
    bus(1'b1, REG_CTRL, 32'h3);
    expect_msg(CODE_CHARGE_COMPLETE, 1'b0);
    bus(1'b1, REG_CTRL, 32'h1);
    new_session();
    $display("register test done");
  endtask
  task automatic t_triggers();
    ptt_flags_t f;
    f = '0;
    f.thermal_control_high = 1'b1;
    delay <= 4'h6;
    fire(f, 1'b0, CODE_CHARGE_COMPLETE);
    fire(f, 1'b1, CODE_CHARGE_COMPLETE);
    delay <= 4'h0;
    f.adapter_present = 1'b1;
    f.temp_hot = 1'b1;
    fire(f, 1'b0, CODE_OVER_TEMPERATURE);
    f.junction_hot = 1'b1;
    fire(f, 1'b0, CODE_INTERNAL_FAULT);
    f = '0;
    f.current_limit_pin_too_small = 1'b1;
    fire(f, 1'b0, CODE_INTERNAL_FAULT);
    f = '0;
    f.thermal_control_low = 1'b1;
    fire(f, 1'b0, CODE_OVER_TEMPERATURE);
    f = '0;
    f.adapter_present = 1'b1;
    fire(f, 1'b0, CODE_UNKNOWN);
    $display("trigger test done");
  endtask
  task automatic t_adapter();
    ptt_flags_t f;
    f = '0;
    f.adapter_enable = 1'b1;
    flags <= f;
    expect_msg(CODE_UNKNOWN, 1'b0);
    chk(32'(sw), 32'h1);
    new_session();
    chk(32'(sw), 32'h0);
    $display("adapter test done");
  endtask
  task automatic t_noconv();
    cep_pulses(63);
    repeat (6) @(posedge clock_in);
    chk(32'(valid), 32'h0);
    cep_pulses(1);
    expect_msg(CODE_OVER_VOLTAGE, 1'b0);
    bus(1'b0, REG_CEP_COUNT, 32'h0);
    chk(q, 32'(CEP_LIMIT));
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0000_0438);
    new_session();
    $display("convergence test done");
  endtask
  task automatic t_term();
    ptt_flags_t f;
    f = '0;
    f.term_above_limit = 1'b1;
    flags <= f;
    repeat (10) @(posedge clock_in);
    chk(32'({valid, oe}), 32'h1);
    fire(f, 1'b1, CODE_CHARGE_COMPLETE);
    $display("termination current test done");
  endtask
  task automatic t_irq();
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(32'(q[0]), 32'h1);
    bus(1'b1, REG_IRQ_STATUS, 32'h1f);
    chk(32'(irq), 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    $display("interrupt test done");
  endtask
  task automatic t_boost();
    ptt_flags_t f;
    f = '0;
    f.term_resistor_fitted = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i == 1) f.load_above_100ma = 1'b1;
      if (i == 2) f.load_above_350ma = 1'b1;
      if (i == 3) f = '0;
      if (i == 3) f.tmem_high = 1'b1;
      if (i == 4) f.rectifier_node_converged = 1'b1;
      flags <= f;
      repeat (5) @(posedge clock_in);
      chk(32'({blo, bmo}), 32'(i == 0 || i == 4 ? 2'h3 : i == 1 || i == 3 ? 2'h1 : 2'h0));
    end
    flags <= '0;
    $display("boost test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // The tests need about 400 cycles; fifty times that means a hang.
  initial begin
    repeat (20000) @(posedge clock_in);
    fails++;
    end_of_test();
  end
  initial begin
    reset_n_in = 1'b0;
    req = '0;
    flags = '0;
    {pma, start, cep} = 3'h0;
    delay = 4'h0;
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    t_regs();
    t_triggers();
    t_adapter();
    t_noconv();
    t_term();
    t_irq();
    t_boost();
    end_of_test();
  end
endmodule
